// ### design/abs_exec_params.svh
// constants for the magnitude execute unit
`ifndef ABS_EXEC_PARAMS_SVH
`define ABS_EXEC_PARAMS_SVH

// ==================================================
// register offsets (byte addresses; the two window bases match address bits 11..7)
`define ADR_FLAGS 12'h000
`define ADR_INSTR 12'h004
`define ADR_MEM_OPERAND 12'h008
`define ADR_STORE_DATA 12'h00C
`define ADR_STORE_INFO 12'h010
`define ADR_STATUS 12'h014
`define ADR_MASK 12'h018
`define ADR_REG_MAN_BASE 5'h02
`define ADR_REG_EXP_BASE 5'h03

// ==================================================
// flag_register bit positions and reset value
`define FLG_C 0
`define FLG_V 1
`define FLG_Z 2
`define FLG_N 3
`define FLG_UF 4
`define FLG_LV 5
`define FLG_LUF 6
`define FLG_SAT 7
`define FLAGS_RESET 8'h00

// ==================================================
// interrupt status bits
`define EV_DONE 0
`define EV_OVF 1
`define EV_ILL 2
`define EV_RESET 3'h0

// ==================================================
// instruction encodings
`define PAR_OPC 7'h64
`define PAR_ZERO 3'h0
`define INT_OPC 9'h001
`define PAR_MOD_LIM 5'h18
`define MODE_REG 2'h0
`define MODE_DIRECT 2'h1
`define MODE_INDIRECT 2'h2
`define MODE_IMM 2'h3
`define EXT_REG_COUNT 5'h08

// ==================================================
// number encodings
`define INT_MIN 32'h80000000
`define INT_MAX 32'h7FFFFFFF
`define FLT_OVF_EXP 8'h7F
`define FLT_ZERO_EXP 8'h80
`define MAN_ZERO 32'h00000000
`define EXP_ONE 8'h01

`endif

// ### design/abs_exec_pkg.sv
// types shared by the magnitude execute unit
package abs_exec_pkg;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [11:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} fsm_t;

	typedef struct packed {
		logic ovf;
		logic [7:0] exp;
		logic [31:0] man;
	} fmag_t;

	typedef struct packed {
		fsm_t fsm;
		logic ack;
		logic [31:0] rdat;
		logic [7:0] flags;
		logic [31:0] instr;
		logic [31:0] mem_operand;
		logic [31:0] store_data;
		logic [16:0] store_info;
		logic [2:0] status;
		logic [2:0] mask;
		logic [31:0][39:0] regs;
	} state_t;

endpackage

// ### design/abs_exec_unit.sv
// magnitude execute unit with wishbone register access
//
// Overview of operation
// - parallel form: bits 31..25 = 1100100, dst1, 000, src3, dst2, src2.
// - parallel form: float magnitude of memory operand, plus store of a register.
// - sources read at execute start, results committed at its end.
// - same memory location: source fetched before the store is written.
// - store register equals magnitude destination: store takes the old value.
// - float mantissa 80000000h with exponent 7Fh overflows to 7FFFFFFFh, 7Fh.
// - float: keep latched underflow and carry, clear UF and N, latch overflow.
// - float: overflow flag set on overflow, cleared otherwise.
// - float magnitude ignores saturate_mode.
// - integer magnitude: signed source, absolute value into any CPU register.
// - integer mode field: 00 register, 01 direct, 10 indirect, 11 immediate.
// - integer 80000000h overflows; saturate gives 7FFFFFFFh, else 80000000h.
// - integer flags change only when destination is R0 to R7.
// - integer: keep latched underflow and carry, clear UF and N, latch overflow.
// - integer: overflow flag set on overflow, cleared otherwise.
// - parallel memory operands indirect with 0, 1, index registers; regs R0..R7.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`include "abs_exec_params.svh"

module abs_exec_unit (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire abs_exec_pkg::wb_req_t WB_REQ,
	output abs_exec_pkg::wb_rsp_t WB_RSP,
	output logic IRQ
);
	import abs_exec_pkg::*;

	// ==================================================
	// helpers

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// float magnitude, same result whatever saturate_mode holds
	function automatic fmag_t fabs(input logic [7:0] e, input logic [31:0] m);
		fmag_t r;
		r.ovf = 1'b0;
		r.exp = e;
		r.man = m;
		if (e == `FLT_ZERO_EXP) begin
			r.man = `MAN_ZERO;
		end else if (m == `INT_MIN) begin
			if (e == `FLT_OVF_EXP) begin
				r.ovf = 1'b1;
				r.man = `INT_MAX;
			end else begin
				// -2 * 2^e becomes 1.0 * 2^(e+1)
				r.exp = e + `EXP_ONE;
				r.man = `MAN_ZERO;
			end
		end else if (m[31]) begin
			r.man = -m;
		end
		return r;
	endfunction

	// flag update shared by both magnitude forms
	function automatic logic [7:0] mag_flags(input logic [7:0] f, input logic ovf,
		input logic zero);
		logic [7:0] r;
		r = f;
		r[`FLG_UF] = 1'b0;
		r[`FLG_N] = 1'b0;
		r[`FLG_Z] = zero;
		r[`FLG_V] = ovf;
		if (ovf) begin
			r[`FLG_LV] = 1'b1;
		end
		return r;
	endfunction

	// short indirect modifier: displacement 0 or 1, or an index register
	function automatic logic short_mod(input logic [7:0] m);
		return m[7:3] < `PAR_MOD_LIM;
	endfunction

	// ==================================================
	// state

	state_t st;
	state_t next_st;

	// ==================================================
	// decode and datapath signals

	logic is_par;
	logic is_int;
	logic par_legal;
	logic [2:0] dst1;
	logic [2:0] src3;
	logic [7:0] dst2;
	logic [7:0] src2;
	logic [1:0] int_mode;
	logic [4:0] int_dst;
	logic [15:0] int_src;
	logic [31:0] int_val;
	logic int_ovf;
	logic [31:0] int_res;
	fmag_t fres;
	logic [39:0] store_reg;
	logic wb_req;
	logic wb_done;
	logic [4:0] reg_idx;
	logic in_man_win;
	logic in_exp_win;
	logic [31:0] flag_word;
	logic [31:0] mask_word;
	logic [31:0] man_word;
	logic [31:0] exp_word;

	always_comb begin
		is_par = (st.instr[31:25] == `PAR_OPC) && (st.instr[21:19] == `PAR_ZERO);
		is_int = (st.instr[31:23] == `INT_OPC);
		dst1 = st.instr[24:22];
		src3 = st.instr[18:16];
		dst2 = st.instr[15:8];
		src2 = st.instr[7:0];
		int_mode = st.instr[22:21];
		int_dst = st.instr[20:16];
		int_src = st.instr[15:0];
		par_legal = short_mod(dst2) && short_mod(src2);

		case (int_mode)
			`MODE_REG: int_val = st.regs[int_src[4:0]][31:0];
			`MODE_DIRECT: int_val = st.mem_operand;
			`MODE_INDIRECT: int_val = st.mem_operand;
			default: int_val = {{16{int_src[15]}}, int_src};
		endcase

		int_ovf = (int_val == `INT_MIN);
		if (int_ovf) begin
			int_res = st.flags[`FLG_SAT] ? `INT_MAX : `INT_MIN;
		end else begin
			int_res = int_val[31] ? -int_val : int_val;
		end

		// memory operand is latched before the store goes out
		fres = fabs(st.mem_operand[31:24], {st.mem_operand[23:0], 8'h00});
		// store source read from the pre-execute register copy
		store_reg = st.regs[src3];
	end

	// ==================================================
	// wishbone decode

	always_comb begin
		wb_req = WB_REQ.cyc && WB_REQ.stb;
		// the write and read-clear act on the edge that samples ack
		wb_done = wb_req && st.ack;
		reg_idx = WB_REQ.adr[6:2];
		in_man_win = (WB_REQ.adr[11:7] == `ADR_REG_MAN_BASE);
		in_exp_win = (WB_REQ.adr[11:7] == `ADR_REG_EXP_BASE);
		// byte-merged write words; narrow registers take their low bits
		flag_word = merge({24'h0, st.flags}, WB_REQ.dat, WB_REQ.sel);
		mask_word = merge({29'h0, st.mask}, WB_REQ.dat, WB_REQ.sel);
		man_word = merge(st.regs[reg_idx][31:0], WB_REQ.dat, WB_REQ.sel);
		exp_word = merge({24'h0, st.regs[reg_idx][39:32]}, WB_REQ.dat, WB_REQ.sel);
	end

	// ==================================================
	// next state

	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;

		// ----- bus write and read-side effects
		if (wb_done && WB_REQ.we) begin
			case (WB_REQ.adr)
				`ADR_FLAGS: next_st.flags = flag_word[7:0];
				`ADR_INSTR: begin
					next_st.instr = merge(st.instr, WB_REQ.dat, WB_REQ.sel);
					next_st.fsm = ST_EXEC;
				end
				`ADR_MEM_OPERAND: next_st.mem_operand = merge(st.mem_operand,
					WB_REQ.dat, WB_REQ.sel);
				`ADR_MASK: next_st.mask = mask_word[2:0];
				default: begin
					if (in_man_win) begin
						next_st.regs[reg_idx][31:0] = man_word;
					end else if (in_exp_win) begin
						next_st.regs[reg_idx][39:32] = exp_word[7:0];
					end
				end
			endcase
		end
		// status clears on read; events below may set it again
		if (wb_done && !WB_REQ.we && (WB_REQ.adr == `ADR_STATUS)) begin
			next_st.status = `EV_RESET;
		end

		// ----- bus answer, held off during the execute cycle
		if (wb_req && !st.ack && (st.fsm == ST_IDLE)) begin
			next_st.ack = 1'b1;
			case (WB_REQ.adr)
				`ADR_FLAGS: next_st.rdat = {24'h0, st.flags};
				`ADR_INSTR: next_st.rdat = st.instr;
				`ADR_MEM_OPERAND: next_st.rdat = st.mem_operand;
				`ADR_STORE_DATA: next_st.rdat = st.store_data;
				`ADR_STORE_INFO: next_st.rdat = {15'h0, st.store_info};
				`ADR_STATUS: next_st.rdat = {29'h0, st.status};
				`ADR_MASK: next_st.rdat = {29'h0, st.mask};
				default: begin
					if (in_man_win) begin
						next_st.rdat = st.regs[reg_idx][31:0];
					end else if (in_exp_win) begin
						next_st.rdat = {24'h0, st.regs[reg_idx][39:32]};
					end else begin
						next_st.rdat = 32'h0;
					end
				end
			endcase
		end

		// ----- execute
		case (st.fsm)
			ST_IDLE: begin
				next_st.fsm = next_st.fsm;
			end
			ST_EXEC: begin
				next_st.fsm = ST_IDLE;
				next_st.status[`EV_DONE] = 1'b1;
				if (is_par && par_legal) begin
					// commit all results at end of the cycle
					// magnitude to dst1, store of src3
					next_st.regs[dst1] = {fres.exp, fres.man};
					next_st.store_data = {store_reg[39:32], store_reg[31:8]};
					next_st.store_info = {1'b1, dst2, src2};
					next_st.flags = mag_flags(st.flags, fres.ovf,
						fres.exp == `FLT_ZERO_EXP);
					if (fres.ovf) begin
						next_st.status[`EV_OVF] = 1'b1;
					end
				end else if (is_int) begin
					next_st.regs[int_dst][31:0] = int_res;
					next_st.store_info[16] = 1'b0;
					if (int_dst < `EXT_REG_COUNT) begin
						next_st.flags = mag_flags(st.flags, int_ovf, int_res == `MAN_ZERO);
					end
					if (int_ovf) begin
						next_st.status[`EV_OVF] = 1'b1;
					end
				end else begin
					next_st.store_info[16] = 1'b0;
					next_st.status[`EV_ILL] = 1'b1;
				end
			end
			default: begin
				next_st.fsm = ST_IDLE;
			end
		endcase
	end

	// ==================================================
	// registers

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			st <= '0;
			st.fsm <= ST_IDLE;
			st.flags <= `FLAGS_RESET;
			st.status <= `EV_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ==================================================
	// outputs

	always_comb begin
		WB_RSP.ack = st.ack;
		WB_RSP.dat = st.rdat;
		IRQ = |(st.status & st.mask);
	end

endmodule // abs_exec_unit

// ### test/abs_exec_unit_assertions.sv
// port checker for the magnitude execute unit
`timescale 1ns/100ps
`include "abs_exec_params.svh"
module abs_exec_unit_assertions (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire abs_exec_pkg::wb_req_t WB_REQ,
	input wire abs_exec_pkg::wb_rsp_t WB_RSP,
	input wire logic IRQ
);
	import abs_exec_pkg::*;
	logic wr, rf, ii, ip, pl, fv, clr, mz;
	logic [7:0] fw;
	logic [31:0] d;
	assign d = WB_REQ.dat;
	assign wr = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & WB_RSP.ack;
	assign rf = WB_REQ.cyc & !WB_REQ.we & WB_RSP.ack & (WB_REQ.adr == `ADR_FLAGS);
	assign ii = d[31:23] == `INT_OPC;
	assign ip = d[31:25] == `PAR_OPC;
	// illegal parallel words commit nothing, so they clear no flags
	assign pl = ip & (d[21:19] == `PAR_ZERO) & (d[15:11] < `PAR_MOD_LIM)
		& (d[7:3] < `PAR_MOD_LIM);
	// ==================================================
	// shadow of software flag writes
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			fw <= `FLAGS_RESET;
			fv <= 1'h1;
			clr <= 1'h0;
			mz <= 1'h1;
		end else if (wr) begin
			if (WB_REQ.adr == `ADR_FLAGS) begin
				fw <= d[7:0];
				fv <= 1'h1;
				clr <= 1'h0;
			end
			if (WB_REQ.adr == `ADR_INSTR) begin
				// shadow stays valid only for integer words with high destinations
				fv <= fv & ii & (d[20:16] >= `EXT_REG_COUNT);
				clr <= pl | (ii & (d[20:16] < `EXT_REG_COUNT));
			end
			if (WB_REQ.adr == `ADR_MASK)
				mz <= d[2:0] == 3'h0;
		end
	end
	// ==================================================
	// assertions
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	ack_pulse_a: assert property (WB_RSP.ack |=> !WB_RSP.ack)
		else $error("ack held past one cycle");
	ack_bound_a: assert property (
		WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |-> ##[1:2] WB_RSP.ack)
		else $error("ack late");
	reset_quiet_a: assert property (
		disable iff (1'h0) RST |=> !WB_RSP.ack && !IRQ)
		else $error("outputs active in reset");
	irq_mask_a: assert property (mz |-> !IRQ)
		else $error("irq with empty mask");
	flag_clear_a: assert property (rf && clr |-> WB_RSP.dat[4:3] == 2'h0)
		else $error("underflow or negative left set");
	flag_keep_a: assert property (rf && fv |-> WB_RSP.dat[7:0] == fw)
		else $error("flags changed by high destination");
	flag_hold_a: assert property (
		rf |-> {WB_RSP.dat[7:6], WB_RSP.dat[0]} == {fw[7:6], fw[0]})
		else $error("carry, latched underflow or mode changed");
	latch_ovf_a: assert property (rf && fw[5] |-> WB_RSP.dat[5])
		else $error("latched overflow lost");
endmodule // abs_exec_unit_assertions

bind abs_exec_unit abs_exec_unit_assertions abs_exec_unit_assertions_i (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.WB_REQ(WB_REQ),
	.WB_RSP(WB_RSP),
	.IRQ(IRQ)
);

// ### test/test_abs_value_store_exec_unit.sv
// self-checking bench for the magnitude execute unit
`timescale 1ns/100ps
`include "abs_exec_params.svh"
module test_abs_value_store_exec_unit;
	import abs_exec_pkg::*;
	logic CORE_CLK = 1'h0;
	logic RST = 1'h1;
	wb_req_t WB_REQ = '0;
	wb_rsp_t WB_RSP;
	logic IRQ;
	int fail_count = 0;
	int checked = 0;
	logic [31:0] exp_q[$];
	string name_q[$];
	logic [31:0] lfsr = 32'h6E0E;
	logic [31:0] v;
	logic [7:0] f;
	logic [31:0] fm[4] = '{32'h05C00000, 32'h7F800000, 32'h7F800000, 32'h80000000};
	logic [39:0] fr[4] = '{40'h0540000000, 40'h7F7FFFFFFF, 40'h7F7FFFFFFF, 40'h8000000000};

	always #12.5 CORE_CLK = ~CORE_CLK;

	abs_exec_unit abs_exec_unit_i (
		.CORE_CLK(CORE_CLK),
		.RST(RST),
		.WB_REQ(WB_REQ),
		.WB_RSP(WB_RSP),
		.IRQ(IRQ)
	);

	// ==================================================
	// helpers
	task automatic summarize();
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic logic [31:0] nf(logic [7:0] fl, logic z, logic o);
		return {24'h0, fl[7:5] | {2'h0, o}, 2'h0, z, o, fl[0]};
	endfunction

	task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
		int n = 0;
		WB_REQ <= '{1'h1, 1'h1, w, a, 4'hF, d};
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (WB_RSP.ack !== 1'h1 && n < 20);
		WB_REQ <= '0;
		if (WB_RSP.ack !== 1'h1) begin
			fail_count++;
			summarize();
		end
		@(posedge CORE_CLK);
	endtask

	task automatic rd(logic [11:0] a, logic [31:0] e, string n);
		exp_q.push_back(e);
		name_q.push_back(n);
		bus(1'h0, a, 32'h0);
	endtask

	// read answers are matched against the oldest note
	always @(posedge CORE_CLK)
		if (WB_RSP.ack === 1'h1 && WB_REQ.we === 1'h0 && exp_q.size() > 0)
			chk(name_q.pop_front(), exp_q.pop_front(), WB_RSP.dat);

	task automatic run(logic [31:0] ins, logic [7:0] fl, logic [11:0] ra,
		logic [39:0] res, logic [31:0] ef);
		bus(1'h1, `ADR_FLAGS, {24'h0, fl});
		bus(1'h1, `ADR_INSTR, ins);
		repeat (2) @(posedge CORE_CLK);
		chk("irq", {31'h0, ef[1]}, {31'h0, IRQ});
		rd(`ADR_STATUS, {30'h0, ef[1], 1'h1}, "status");
		chk("irq_clr", 32'h0, {31'h0, IRQ});
		rd(`ADR_FLAGS, ef, "flags");
		rd(ra, res[31:0], "man");
		rd(ra + 12'h080, {24'h0, res[39:32]}, "exp");
	endtask

	// ==================================================
	// main sequence
	initial begin
		repeat (5) @(posedge CORE_CLK);
		RST <= 1'h0;
		@(posedge CORE_CLK);
		rd(`ADR_FLAGS, 32'h0, "flags_rst");
		rd(`ADR_MASK, 32'h0, "mask_rst");
		bus(1'h1, 12'h300, 32'hFFFFFFFF);
		rd(12'h300, 32'h0, "unmapped");
		bus(1'h1, `ADR_MASK, 32'h2);
		rd(`ADR_MASK, 32'h2, "mask");
		v = rnd() | 32'h80000001;
		bus(1'h1, 12'h124, v);
		run({9'h001, 2'h0, 5'h03, 16'h0009}, 8'h59, 12'h10C, {8'h0, -v},
			nf(8'h59, 1'h0, 1'h0));
		bus(1'h1, `ADR_MEM_OPERAND, `INT_MIN);
		run({9'h001, 2'h1, 5'h05, 16'h0000}, 8'hD9, 12'h114, {8'h0, `INT_MAX},
			nf(8'hD9, 1'h0, 1'h1));
		run({9'h001, 2'h2, 5'h06, 16'h0000}, 8'h59, 12'h118, {8'h0, `INT_MIN},
			nf(8'h59, 1'h0, 1'h1));
		bus(1'h1, 12'h11C, 32'h1);
		run({9'h001, 2'h3, 5'h07, 16'h0000}, 8'h79, 12'h11C, 40'h0,
			nf(8'h79, 1'h1, 1'h0));
		run({9'h001, 2'h3, 5'h0C, 16'h0035}, 8'h59, 12'h130, 40'h35, 32'h59);
		for (int i = 0; i < 4; i++) begin
			f = (i == 2) ? 8'hD9 : 8'h59;
			bus(1'h1, 12'h110, 32'h33C00000);
			bus(1'h1, 12'h190, 32'h07);
			bus(1'h1, `ADR_MEM_OPERAND, fm[i]);
			run({7'h64, 3'h4, 3'h0, 3'h4, 8'h08, 8'h08}, f, 12'h110, fr[i],
				nf(f, i == 3, i == 1 || i == 2));
			rd(`ADR_STORE_DATA, 32'h0733C000, "store");
			rd(`ADR_STORE_INFO, 32'h00010808, "info");
		end
		// long modifier in dst2: illegal, nothing committed, store marked invalid
		bus(1'h1, `ADR_FLAGS, 32'h59);
		bus(1'h1, `ADR_MASK, 32'h4);
		bus(1'h1, `ADR_INSTR, {7'h64, 3'h5, 3'h0, 3'h4, 8'hC0, 8'h08});
		repeat (2) @(posedge CORE_CLK);
		chk("irq_ill", 32'h1, {31'h0, IRQ});
		rd(`ADR_STATUS, 32'h5, "status_ill");
		rd(`ADR_STORE_INFO, 32'h00000808, "info_ill");
		rd(`ADR_FLAGS, 32'h59, "flags_ill");
		rd(12'h114, `INT_MAX, "r5_kept");
		summarize();
	end
endmodule // test_abs_value_store_exec_unit
